// ==== src/rcp_div_unit.sv ====
/*
  reciprocal approximation and multiply datapath for division:
  seeded newton reciprocal to 30 bits, correction term 2 - a*b,
  full, full rounded and half precision coefficient multiply.
  assumes the issue logic holds start_i for one cycle only while idle.
*/
// Summary of operation
// [RULE1] starting estimate comes from fixed lookup table
// [RULE2] step: next equals x times two minus xb
// [RULE3] three steps inside, deliver 30-bit reciprocal
// [RULE4] correction operation returns two minus a times b
// [RULE5] correction times estimate gives full reciprocal
// [RULE6] rounded full multiply gives full quotient
// [RULE7] half multiply gives quotient in two operations
// [RULE8] half result: low 19 bits zero, rounded
// [RULE9] program applies correction only once, no fifth
// [RULE10] program never corrects an already exact reciprocal
// [RULE11] correction order may differ two ulps
// [RULE12] complement exponent and add two first
// [RULE13] overflow: clear top bit, exponent 60000, flag
// [RULE14] low operand exponent treated as overflow too
// [RULE15] half round bits at 2^-32, 2^-31, carried
// [RULE16] same sign, exponent, coefficient word format
`timescale 1ns/100ps
module rcp_div_unit
  import rcp_div_pkg::*;
(
  input  wire logic                            mclk_i,
  input  wire logic                            srst_i,
  input  wire logic                            start_i,
  input  wire rcp_div_pkg::op_t                op_i,
  input  wire logic [rcp_div_pkg::WORD_W-1:0]  opa_i,
  input  wire logic [rcp_div_pkg::WORD_W-1:0]  opb_i,
  output logic                                 busy_o,
  output logic                                 done_o,
  output logic      [rcp_div_pkg::WORD_W-1:0]  result_o,
  output logic                                 fp_err_o
);
  // whole state of the unit
  typedef struct packed {
    rcp_state_t        st;    // sequencer state
    logic [1:0]        iter;  // newton step in progress
    logic [EST_W-1:0]  x;     // current estimate
    logic [EST_W-1:0]  e;     // two minus x*b
    logic [DIV_W-1:0]  b;     // divisor coefficient, top bits
    logic              sgn;   // divisor sign
    logic [EXP_W-1:0]  bexp;  // divisor exponent
    logic              done;  // result valid pulse
    logic              err;   // range error pulse
    logic [WORD_W-1:0] res;   // result word
  } state_t;

  state_t q;                       // registered state
  state_t d;                       // next state
  logic [ROM_DW-1:0] seed;         // table output
  logic [2*EST_W-1:0] m;           // shared estimate multiplier
  logic [EST_W-1:0]   mop;         // second multiplier operand
  logic [EST_W-1:0]   t;           // scaled product

  // seed lookup addressed straight from the operand
  rcp_seed_rom u_seed (
    .mclk_i (mclk_i),
    .addr_i (opb_i[ROM_IDX_MSB -: ROM_AW]),
    .data_o (seed)
  );

  // coefficient multiply with optional rounding, normalized result
  function automatic logic [WORD_W-1:0] fmul(
    input logic [WORD_W-1:0] a,
    input logic [WORD_W-1:0] b,
    input op_t               op
  );
    logic [PROD_W-1:0] p;
    logic [16:0]       ex;
    logic [COEF_W-1:0] c;
    logic              sg;
    p  = a[EXP_LSB-1:0] * b[EXP_LSB-1:0];
    ex = {2'h0, a[EXP_MSB:EXP_LSB]} + {2'h0, b[EXP_MSB:EXP_LSB]}
         - {2'h0, EXP_BIAS};
    sg = a[SIGN_BIT] ^ b[SIGN_BIT];
    if (op == OP_MUL_RND) begin
      // two round bits, carry allowed upward
      p = p + (PROD_W'(1) << RND_FULL_HI)
            + (PROD_W'(1) << RND_FULL_LO); // [RULE6]
    end else if (op == OP_MUL_HALF) begin
      p = p + (PROD_W'(1) << RND_HALF_HI)
            + (PROD_W'(1) << RND_HALF_LO); // [RULE15]
    end
    if (p[PROD_W-1]) begin
      c = p[PROD_W-1 -: COEF_W];
    end else begin
      // one place left shift, exponent down one
      c  = p[PROD_W-2 -: COEF_W];
      ex = ex - 17'h1;
    end
    if (op == OP_MUL_HALF) begin
      // keep the 29 upper bits, low 19 forced to zero
      c = {c[COEF_W-1 -: HALF_KEEP], {HALF_ZERO{1'b0}}}; // [RULE8] [RULE7]
    end
    fmul = {sg, ex[EXP_W-1:0], c}; // [RULE16]
  endfunction : fmul

  // correction term: two minus the product, as a float
  function automatic logic [WORD_W-1:0] fcorr(
    input logic [WORD_W-1:0] a,
    input logic [WORD_W-1:0] b
  );
    logic [WORD_W-1:0] p;
    logic [CORR_W-1:0] v;
    logic [CORR_W-1:0] r;
    logic [EXP_W-1:0]  pe;
    p  = fmul(a, b, OP_MUL_FULL);
    pe = p[EXP_MSB:EXP_LSB];
    // product near one: align to two integer bits
    if (pe == EXP_BIAS + 15'h1) begin
      v = {1'b0, p[COEF_W-1:0], 1'b0};
    end else begin
      v = {2'b00, p[COEF_W-1:0]};
    end
    r = CORR_TWO - v; // [RULE4]
    if (r[CORR_W-2]) begin
      fcorr = {1'b0, EXP_BIAS + 15'h1, r[CORR_W-2 -: COEF_W]};
    end else begin
      fcorr = {1'b0, EXP_BIAS, r[COEF_W-1:0]};
    end
  endfunction : fcorr

  // pack the refined estimate with the reciprocal exponent
  function automatic logic [WORD_W:0] rpack(
    input logic              sg,
    input logic [EXP_W-1:0]  be,
    input logic [EST_W-1:0]  x
  );
    logic [EXP_W-1:0]  re;
    logic [COEF_W-1:0] c;
    logic              ovf;
    re = ~be + RCP_EXP_ADD; // [RULE12]
    if (x[EST_W-1]) begin
      // estimate reached two: renormalize
      c  = {x, {(COEF_W-EST_W){1'b0}}};
      re = re + 15'h1;
    end else begin
      c = {x[EST_W-2:0], {(COEF_W-EST_W+1){1'b0}}};
    end
    ovf = (re >= RCP_OVF_LIM) || (be <= RCP_UNF_LIM); // [RULE13] [RULE14]
    if (ovf) begin
      c[COEF_W-1] = 1'b0;
      re          = RCP_OVF_EXP; // [RULE13]
    end
    rpack = {ovf, sg, re, c}; // [RULE16]
  endfunction : rpack

  // shared multiplier: x*b in the product phase, x*e when refining
  always_comb begin
    mop = (q.st == S_PROD) ? {2'b00, q.b} : q.e;
    m   = q.x * mop;
    t   = m[EST_FRAC +: EST_W];
  end

  // next state
  always_comb begin
    logic [WORD_W:0] pk;
    pk     = '0;
    d      = q;
    d.done = 1'b0;
    d.err  = 1'b0;
    case (q.st)
      S_IDLE: begin
        if (start_i) begin
          if (op_i == OP_RECIP) begin
            // latch divisor, table read under way
            d.b    = opb_i[COEF_W-1 -: DIV_W];
            d.sgn  = opb_i[SIGN_BIT];
            d.bexp = opb_i[EXP_MSB:EXP_LSB];
            d.iter = 2'h0;
            d.st   = S_SEED;
          end else if (op_i == OP_CORR) begin
            d.res  = fcorr(opa_i, opb_i); // [RULE4] [RULE5]
            d.done = 1'b1;
          end else begin
            d.res  = fmul(opa_i, opb_i, op_i); // [RULE5] [RULE6] [RULE7]
            d.done = 1'b1;
          end
        end
      end
      S_SEED: begin
        // table value becomes the first estimate
        d.x  = EST_W'({seed, {SEED_SHIFT{1'b0}}}); // [RULE1]
        d.st = S_PROD;
      end
      S_PROD: begin
        d.e  = EST_TWO - t; // [RULE2]
        d.st = S_REFINE;
      end
      S_REFINE: begin
        d.x = t; // [RULE2]
        if (q.iter == NEWTON_LAST) begin
          // third step done: deliver the 30-bit reciprocal
          pk     = rpack(q.sgn, q.bexp, t); // [RULE3]
          d.res  = pk[WORD_W-1:0];
          d.err  = pk[WORD_W];
          d.done = 1'b1;
          d.st   = S_IDLE;
        end else begin
          d.iter = q.iter + 2'h1; // [RULE3]
          d.st   = S_PROD;
        end
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase
  end

  // state register, synchronous reset
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      q      <= '0;
      q.st   <= S_IDLE;
    end else begin
      q <= d;
    end
  end

  assign busy_o   = (q.st != S_IDLE);
  assign done_o   = q.done;
  assign result_o = q.res;
  assign fp_err_o = q.err;
endmodule : rcp_div_unit

// ==== src/rcp_div_pkg.sv ====
/*
  constants and types shared by the reciprocal / division datapath:
  word layout, exponent limits, rounding positions, opcodes, states.
  assumes 64-bit words: sign, 15-bit biased exponent, 48-bit coefficient.
*/
package rcp_div_pkg;
  // word layout
  localparam int WORD_W   = 64;
  localparam int SIGN_BIT = 63;
  localparam int EXP_MSB  = 62;
  localparam int EXP_LSB  = 48;
  localparam int EXP_W    = 15;
  localparam int COEF_W   = 48;
  localparam int PROD_W   = 96;
  localparam logic [EXP_W-1:0] EXP_BIAS    = 15'h4000; // octal 40000
  // reciprocal exponent handling
  localparam logic [EXP_W-1:0] RCP_EXP_ADD = 15'h0002;
  localparam logic [EXP_W-1:0] RCP_OVF_LIM = 15'h6002; // octal 60002
  localparam logic [EXP_W-1:0] RCP_OVF_EXP = 15'h6000; // octal 60000
  localparam logic [EXP_W-1:0] RCP_UNF_LIM = 15'h2001; // octal 20001
  // seed table
  localparam int ROM_AW    = 6;
  localparam int ROM_DEPTH = 64;
  localparam int ROM_DW    = 9;   // estimate, one integer bit, 8 fraction
  localparam int ROM_NUM   = 65536;
  localparam int ROM_IDX_MSB = 46; // coefficient bits below the leading one
  // newton estimate, two integer bits and 32 fraction bits
  localparam int EST_W     = 34;
  localparam int EST_FRAC  = 32;
  localparam int DIV_W     = 32;   // divisor bits used by the refinement
  localparam int SEED_SHIFT = 24;
  localparam logic [EST_W-1:0] EST_TWO = 34'h2_0000_0000;
  localparam logic [1:0] NEWTON_LAST = 2'h2; // steps 0..2, three in all
  // multiply rounding positions inside the 96-bit product
  localparam int RND_FULL_HI = 46;  // 2^-50
  localparam int RND_FULL_LO = 45;  // 2^-51
  localparam int RND_HALF_HI = 65;  // 2^-31
  localparam int RND_HALF_LO = 64;  // 2^-32
  localparam int HALF_KEEP   = 29;
  localparam int HALF_ZERO   = 19;
  // correction term fixed point, two integer bits, 48 fraction bits
  localparam int CORR_W = 50;
  localparam logic [CORR_W-1:0] CORR_TWO = 50'h2_0000_0000_0000;

  // operation select
  typedef enum logic [2:0] {
    OP_RECIP    = 3'h0,
    OP_CORR     = 3'h1,
    OP_MUL_FULL = 3'h2,
    OP_MUL_RND  = 3'h3,
    OP_MUL_HALF = 3'h4
  } op_t;

  // reciprocal sequencer, one-hot
  typedef enum logic [3:0] {
    S_IDLE   = 4'b0001,
    S_SEED   = 4'b0010,
    S_PROD   = 4'b0100,
    S_REFINE = 4'b1000
  } rcp_state_t;
endpackage : rcp_div_pkg

// ==== src/rcp_seed_rom.sv ====
/*
  seed table for the reciprocal: 64 entries of a 9-bit first guess,
  indexed by the six coefficient bits under the leading one.
  assumes a normalized divisor; read data are registered, one cycle late.
*/
`timescale 1ns/100ps
module rcp_seed_rom
  import rcp_div_pkg::*;
(
  input  wire logic                            mclk_i,
  input  wire logic [rcp_div_pkg::ROM_AW-1:0]  addr_i,
  output logic      [rcp_div_pkg::ROM_DW-1:0]  data_o
);
  logic [ROM_DW-1:0] table_w [ROM_DEPTH]; // constant contents
  logic [ROM_DW-1:0] data_q;              // registered read

  // each entry is 1/b at the middle of its slice, scaled by 256
  for (genvar i = 0; i < ROM_DEPTH; i++) begin : g_entry
    localparam int VAL = ROM_NUM / (2 * ROM_DEPTH + 1 + 2 * i);
    assign table_w[i] = ROM_DW'(VAL);
  end

  // registered read port
  always_ff @(posedge mclk_i) begin
    data_q <= table_w[addr_i];
  end

  assign data_o = data_q;
endmodule : rcp_seed_rom

// ==== tb/rcp_div_unit_asserts.sv ====
/*
  port checker for the reciprocal / division datapath.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module rcp_div_unit_asserts
  import rcp_div_pkg::*;
(
  input wire logic             mclk_i,
  input wire logic             srst_i,
  input wire logic             start_i,
  input wire rcp_div_pkg::op_t op_i,
  input wire logic [63:0]      opa_i,
  input wire logic [63:0]      opb_i,
  input wire logic             busy_o,
  input wire logic             done_o,
  input wire logic [63:0]      result_o,
  input wire logic             fp_err_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  logic take;  // request accepted at this edge
  logic rcp;   // accepted reciprocal request
  assign take = start_i && !busy_o;
  assign rcp  = take && op_i == OP_RECIP;
  AST_MUL_LAT: assert property (take && !rcp |=> done_o && !fp_err_o)
    else $error("multiply answer missing");
  AST_RCP_LAT: assert property (rcp |=> busy_o[*7] ##1 (done_o && !busy_o))
    else $error("reciprocal timing wrong");
  AST_RCP_EXP: assert property (rcp && opb_i[62:48] > RCP_UNF_LIM |-> ##8
    result_o[62:48] == ~$past(opb_i[62:48], 8) + RCP_EXP_ADD && !fp_err_o)
    else $error("reciprocal exponent wrong");
  AST_RCP_ERR: assert property (rcp && opb_i[62:48] <= RCP_UNF_LIM |-> ##8
    fp_err_o && result_o[62:47] == {RCP_OVF_EXP, 1'b0})
    else $error("range error not flagged");
  AST_ERR_DONE: assert property (fp_err_o |-> done_o)
    else $error("error flag without result");
  AST_RCP_SIGN: assert property (rcp |-> ##8 result_o[63] == $past(opb_i[63], 8))
    else $error("reciprocal sign wrong");
  AST_HALF_LOW: assert property (take && op_i == OP_MUL_HALF |=> result_o[18:0] == '0)
    else $error("half result low bits set");
  AST_DONE_CAUSE: assert property (done_o |-> $past(take) || $past(busy_o))
    else $error("result without request");
  cover property (rcp ##8 fp_err_o);
  cover property (take && op_i == OP_CORR ##1 done_o);
  cover property (take && op_i == OP_MUL_HALF ##1 done_o);
endmodule : rcp_div_unit_asserts

bind rcp_div_unit rcp_div_unit_asserts i_chk (
  .mclk_i(mclk_i), .srst_i(srst_i), .start_i(start_i), .op_i(op_i),
  .opa_i(opa_i), .opb_i(opb_i), .busy_o(busy_o), .done_o(done_o),
  .result_o(result_o), .fp_err_o(fp_err_o));

// ==== tb/issue_logic_model.sv ====
/*
  model of the instruction issue logic in front of the datapath.
  assumes callers enter its tasks just after a rising edge.
*/
`timescale 1ns/100ps
module issue_logic_model
  import rcp_div_pkg::*;
(
  input  wire logic             mclk_i,
  input  wire logic             busy_i,
  output logic                  start_o,
  output rcp_div_pkg::op_t      op_o,
  output logic [63:0]           opa_o,
  output logic [63:0]           opb_o
);
  int waits;  // cycles spent waiting for idle
  initial begin
    start_o = 1'b0;
    op_o = OP_MUL_FULL;
    opa_o = '0;
    opb_o = '0;
  end
  // one request; push skips the idle wait to provoke a refusal
  task automatic issue(input op_t op, input logic [63:0] a, b,
                       input logic push);
    waits = 0;
    while (!push && waits < 50) begin
      @(negedge mclk_i);
      if (!busy_i) break;
      waits++;
    end
    @(posedge mclk_i);
    start_o <= 1'b1;
    op_o <= op;
    opa_o <= a;
    opb_o <= b;
  endtask : issue
  // strobe down, released operands inverted once at the same edge
  task automatic release_bus();
    @(posedge mclk_i);
    start_o <= 1'b0;
    opa_o <= ~opa_o;
    opb_o <= ~opb_o;
  endtask : release_bus
endmodule : issue_logic_model

// ==== tb/rcp_div_unit_tb.sv ====
/*
  self-checking bench for the reciprocal / division datapath.
  assumes the issue model and the checker are compiled first.
*/
`timescale 1ns/100ps
module rcp_div_unit_tb;
  import rcp_div_pkg::*;
  typedef struct { logic [63:0] w; logic [63:0] tol; logic err; } exp_t;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic start_i, busy_o, done_o, fp_err_o;
  op_t op_i;
  logic [63:0] opa_i, opb_i, result_o, res_q, a, b, r, h;
  exp_t notes_q[$];  // expected results, oldest first
  int mismatches = 0;
  int checks = 0;
  logic [63:0] rng = 64'h5e;
  always #2 mclk_i = ~mclk_i;
  rcp_div_unit i_dut (.mclk_i(mclk_i), .srst_i(srst_i), .start_i(start_i),
    .op_i(op_i), .opa_i(opa_i), .opb_i(opb_i), .busy_o(busy_o),
    .done_o(done_o), .result_o(result_o), .fp_err_o(fp_err_o));
  issue_logic_model i_iss (.mclk_i(mclk_i), .busy_i(busy_o),
    .start_o(start_i), .op_o(op_i), .opa_o(opa_i), .opb_o(opb_i));
  function automatic logic [63:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 7;
    rng ^= rng << 17;
    return rng;
  endfunction : rnd
  // normalized operand, kept clear of an exact power of two
  function automatic logic [63:0] opnd(logic [14:0] ex);
    logic [63:0] x;
    x = rnd();
    return {x[63], ex, x[47:0] | 48'h8000_1000_0000};
  endfunction : opnd
  function automatic exp_t mul(logic [63:0] x, y, int k);
    exp_t e;
    logic [95:0] p;
    p = 96'(x[47:0]) * y[47:0];
    p += (k == 3) ? 96'h3 << 45 : (k == 4) ? 96'h3 << 64 : 96'h0;
    e.w[63] = x[63] ^ y[63];
    e.w[62:48] = x[62:48] + y[62:48] - EXP_BIAS - {14'h0, !p[95]};
    e.w[47:0] = p[95] ? p[95:48] : p[94:47];
    if (k == 4) e.w[18:0] = '0;
    e.tol = '0;
    e.err = 1'b0;
    return e;
  endfunction : mul
  function automatic exp_t rcp(logic [63:0] y, logic [63:0] tol);
    exp_t e;
    logic [95:0] q;
    q = (96'h1 << 95) / y[47:0];
    e.err = y[62:48] <= RCP_UNF_LIM;
    e.w = {y[63], e.err ? RCP_OVF_EXP : ~y[62:48] + RCP_EXP_ADD, q[47:0]};
    if (e.err) e.w[47] = 1'b0;
    e.tol = tol;
    return e;
  endfunction : rcp
  function automatic exp_t quo(logic [63:0] x, y, logic [63:0] tol);
    exp_t e;
    logic [95:0] q;
    q = (96'(x[47:0]) << (x[47:0] >= y[47:0] ? 47 : 48)) / y[47:0];
    e.w = {x[63] ^ y[63], x[62:48] - y[62:48] + EXP_BIAS
           + {14'h0, x[47:0] >= y[47:0]}, q[47:0]};
    e.tol = tol;
    e.err = 1'b0;
    return e;
  endfunction : quo
  // two minus product, operand exponents summing to one above bias
  function automatic exp_t corr(logic [63:0] x, y);
    exp_t e;
    logic [95:0] t;
    t = (96'h1 << 49) - ((96'(x[47:0]) * y[47:0]) >> 47);
    e.w = {1'b0, t[48] ? 15'h4001 : 15'h4000, t[48] ? t[48:1] : t[47:0]};
    e.tol = 64'h2;
    e.err = 1'b0;
    return e;
  endfunction : corr
  task automatic cmp(input exp_t e, input logic [63:0] g, input logic f);
    logic [63:0] d;
    d = g[47:0] > e.w[47:0] ? g[47:0] - e.w[47:0] : e.w[47:0] - g[47:0];
    checks++;
    if (g[63:48] !== e.w[63:48] || f !== e.err || d > e.tol
        || ^g === 1'bx) begin
      mismatches++;
      $display("ERROR %0t exp %h got %h", $time, e.w, g);
    end
  endtask : cmp
  // result watcher, pops the oldest note per result
  always @(negedge mclk_i) if (!srst_i && done_o !== 1'b0) begin
    res_q = result_o;
    if (notes_q.size() == 0) begin
      mismatches++;
      $display("ERROR %0t exp %h got %h", $time, 64'h0, result_o);
    end else cmp(notes_q.pop_front(), result_o, fp_err_o);
  end
  task automatic req(input op_t op, input logic [63:0] x, y, input exp_t e);
    notes_q.push_back(e);
    i_iss.issue(op, x, y, 1'b0);
    if (op == OP_RECIP) i_iss.release_bus();
  endtask : req
  task automatic drain();
    int n;
    n = 0;
    i_iss.release_bus();
    while (notes_q.size() != 0 && n < 40) begin
      @(posedge mclk_i);
      n++;
    end
    if (notes_q.size() != 0) begin
      mismatches++;
      $display("ERROR %0t exp %h got %h", $time, 64'h0, 64'h0);
      complete_run();
    end
  endtask : drain
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (4) @(posedge mclk_i);
    srst_i <= 1'b0;
    // every multiply code back to back, codes 5..7 act as full
    for (int k = 2; k < 8; k++) begin
      a = opnd(15'h3ffe + 15'(k));
      b = opnd(15'h4003 - 15'(k));
      req(op_t'(k), a, b, mul(a, b, k));
    end
    drain();
    $display("multiply codes done");
    // all seed entries, range limits, one refused request
    for (int i = 0; i < 64; i++) begin
      b = opnd(i == 0 ? 15'h2001 : i == 1 ? 15'h2002 : 15'h3fc0 + 15'(i));
      b[46:41] = 6'(i);
      req(OP_RECIP, rnd(), b, rcp(b, 64'h10_0000));
      if (i == 3) i_iss.issue(OP_MUL_FULL, b, b, 1'b1);
      drain();
    end
    $display("reciprocal sweep done");
    // exact correction terms either side of one
    for (int k = 0; k < 2; k++) begin
      a = {1'b0, 15'h4001, 48'hc000_0000_0000};
      b = {1'b0, 15'h4000, k ? 48'hc000_0000_0000 : 48'h8000_0000_0000};
      req(OP_CORR, a, b, corr(a, b));
    end
    drain();
    $display("correction table done");
    // full and half division, corrected once per reciprocal
    for (int j = 0; j < 6; j++) begin
      a = opnd(15'h4000 + 15'(j));
      b = opnd(15'h3ffd + 15'(j));
      req(OP_RECIP, a, b, rcp(b, 64'h10_0000));
      drain();
      h = res_q;
      req(OP_CORR, h, b, corr(h, b));
      drain();
      req(OP_MUL_FULL, res_q, h, rcp(b, 64'h4));
      drain();
      r = res_q;
      req(OP_MUL_RND, a, r, quo(a, b, 64'h8));
      req(OP_MUL_HALF, a, h, quo(a, b, 64'h20_0000));
      drain();
    end
    $display("division chains done");
    complete_run();
  end
endmodule : rcp_div_unit_tb
